// *** csc_regs.sv ***
// Configuration register bank of the clock synthesizer
`timescale 1ns/1ps
`include "csc_defs.svh"
module csc_regs (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire csc_pkg::csc_addr_t i_addr,
    input wire csc_pkg::csc_byte_t i_wdata,
    input wire logic i_soft_reset,
    output csc_pkg::csc_byte_t o_rdata,
    output logic o_rd_valid,
    output logic o_rd_err,
    output logic o_wr_ack,
    output logic o_ramp_switch_en,
    output logic [2:0] o_ramp_step_size,
    output logic o_reference_external_source_sel,
    output logic o_io_level_3v3,
    output csc_pkg::csc_in_t o_input_buffer_en,
    output csc_pkg::csc_in_t o_input_pulsed_cmos,
    output csc_pkg::csc_in_t o_input_to_detector_route,
    output logic [11:0] o_input_hysteresis_cfg,
    output logic o_feedback_integer_mode,
    output csc_pkg::csc_div_t o_output_div_half_add,
    output csc_pkg::csc_div_t o_synth_to_driver_route,
    output csc_pkg::csc_div_t o_output_div_integer_mode,
    output csc_pkg::csc_div_t o_output_div_power_on,
    output logic o_out_div0_fast_range,
    output logic o_out_div1_fast_range,
    output csc_pkg::csc_in_t o_pll_change_scratch_a,
    output csc_pkg::csc_in_t o_pll_change_scratch_b,
    output csc_pkg::csc_in_t o_input_frac_div_clock_off,
    output logic o_feedback_frac_div_clock_off,
    output csc_pkg::csc_div_t o_output_div_clock_off,
    output csc_pkg::csc_div_t o_int_mode_pending,
    output csc_pkg::csc_div_t o_div_running,
    output csc_pkg::csc_in_t o_input_running,
    output csc_pkg::csc_in_t o_input_frac_running,
    output logic o_feedback_frac_running
);
    import csc_pkg::*;

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    // One byte per mapped address
    csc_byte_t q_ramp;
    csc_byte_t q_ref;
    csc_byte_t q_io;
    csc_byte_t q_in_buf;
    csc_byte_t q_in_route;
    csc_byte_t q_hys_lo;
    csc_byte_t q_hys_hi;
    csc_byte_t q_fb_int;
    csc_byte_t q_half;
    csc_byte_t q_drv_route;
    csc_byte_t q_int_mode;
    csc_byte_t q_power;
    csc_byte_t q_fast0;
    csc_byte_t q_fast1;
    csc_byte_t q_scr_a;
    csc_byte_t q_scr_b;
    csc_byte_t q_frac_gate;
    csc_byte_t q_clk_off;
    logic int_mode_we;

    // Shared by the integer mode field and the pending flags
    assign int_mode_we = i_wr_en && (i_addr == `CSC_ADDR_INT_MODE);

    // ----------------------------------------
    // Device level fields
    // ----------------------------------------
    // Unused bits are dropped inside each field register
    // Ramp step size and ramp enable; enable comes up set
    csc_field_reg #(.MASK(`CSC_MASK_RAMP), .RESET_VAL(`CSC_RST_RAMP)) u_ramp (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(i_wr_en && (i_addr == `CSC_ADDR_RAMP)),
        .i_wdata(i_wdata),
        .o_q(q_ramp)
    );

    csc_field_reg #(.MASK(`CSC_MASK_BIT0), .RESET_VAL(`CSC_RST_ZERO)) u_ref (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(i_wr_en && (i_addr == `CSC_ADDR_REF_SRC)),
        .i_wdata(i_wdata),
        .o_q(q_ref)
    );

    csc_field_reg #(.MASK(`CSC_MASK_BIT0), .RESET_VAL(`CSC_RST_ZERO)) u_io (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(i_wr_en && (i_addr == `CSC_ADDR_IO_LEVEL)),
        .i_wdata(i_wdata),
        .o_q(q_io)
    );

    // ----------------------------------------
    // Clock input and feedback fields
    // ----------------------------------------
    csc_field_reg #(.MASK(`CSC_MASK_BYTE), .RESET_VAL(`CSC_RST_ZERO)) u_in_buf (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(i_wr_en && (i_addr == `CSC_ADDR_IN_BUF)),
        .i_wdata(i_wdata),
        .o_q(q_in_buf)
    );

    csc_field_reg #(.MASK(`CSC_MASK_NIBBLE), .RESET_VAL(`CSC_RST_ZERO)) u_in_route (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(i_wr_en && (i_addr == `CSC_ADDR_IN_ROUTE)),
        .i_wdata(i_wdata),
        .o_q(q_in_route)
    );

    csc_field_reg #(.MASK(`CSC_MASK_BYTE), .RESET_VAL(`CSC_RST_ZERO)) u_hys_lo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(i_wr_en && (i_addr == `CSC_ADDR_HYS_LO)),
        .i_wdata(i_wdata),
        .o_q(q_hys_lo)
    );

    csc_field_reg #(.MASK(`CSC_MASK_NIBBLE), .RESET_VAL(`CSC_RST_ZERO)) u_hys_hi (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(i_wr_en && (i_addr == `CSC_ADDR_HYS_HI)),
        .i_wdata(i_wdata),
        .o_q(q_hys_hi)
    );

    csc_field_reg #(.MASK(`CSC_MASK_BIT0), .RESET_VAL(`CSC_RST_ZERO)) u_fb_int (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(i_wr_en && (i_addr == `CSC_ADDR_FB_INT)),
        .i_wdata(i_wdata),
        .o_q(q_fb_int)
    );

    // ----------------------------------------
    // Output divider fields
    // ----------------------------------------
    csc_field_reg #(.MASK(`CSC_MASK_DIV5), .RESET_VAL(`CSC_RST_ZERO)) u_half (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(i_wr_en && (i_addr == `CSC_ADDR_HALF_ADD)),
        .i_wdata(i_wdata),
        .o_q(q_half)
    );

    csc_field_reg #(.MASK(`CSC_MASK_DIV5), .RESET_VAL(`CSC_RST_ZERO)) u_drv_route (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(i_wr_en && (i_addr == `CSC_ADDR_DRV_ROUTE)),
        .i_wdata(i_wdata),
        .o_q(q_drv_route)
    );

    csc_field_reg #(.MASK(`CSC_MASK_DIV5), .RESET_VAL(`CSC_RST_ZERO)) u_int_mode (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(int_mode_we),
        .i_wdata(i_wdata),
        .o_q(q_int_mode)
    );

    csc_field_reg #(.MASK(`CSC_MASK_DIV5), .RESET_VAL(`CSC_RST_ZERO)) u_power (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(i_wr_en && (i_addr == `CSC_ADDR_DIV_POWER)),
        .i_wdata(i_wdata),
        .o_q(q_power)
    );

    csc_field_reg #(.MASK(`CSC_MASK_FAST), .RESET_VAL(`CSC_RST_ZERO)) u_fast0 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(i_wr_en && (i_addr == `CSC_ADDR_DIV0_FAST)),
        .i_wdata(i_wdata),
        .o_q(q_fast0)
    );

    csc_field_reg #(.MASK(`CSC_MASK_FAST), .RESET_VAL(`CSC_RST_ZERO)) u_fast1 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(i_wr_en && (i_addr == `CSC_ADDR_DIV1_FAST)),
        .i_wdata(i_wdata),
        .o_q(q_fast1)
    );

    // ----------------------------------------
    // PLL change and clock gating fields
    // ----------------------------------------
    csc_field_reg #(.MASK(`CSC_MASK_NIBBLE), .RESET_VAL(`CSC_RST_ZERO)) u_scr_a (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(i_wr_en && (i_addr == `CSC_ADDR_SCRATCH_A)),
        .i_wdata(i_wdata),
        .o_q(q_scr_a)
    );

    csc_field_reg #(.MASK(`CSC_MASK_NIBBLE), .RESET_VAL(`CSC_RST_ZERO)) u_scr_b (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(i_wr_en && (i_addr == `CSC_ADDR_SCRATCH_B)),
        .i_wdata(i_wdata),
        .o_q(q_scr_b)
    );

    csc_field_reg #(.MASK(`CSC_MASK_FRAC_GATE), .RESET_VAL(`CSC_RST_ZERO)) u_frac_gate (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(i_wr_en && (i_addr == `CSC_ADDR_FRAC_GATE)),
        .i_wdata(i_wdata),
        .o_q(q_frac_gate)
    );

    csc_field_reg #(.MASK(`CSC_MASK_DIV5), .RESET_VAL(`CSC_RST_ZERO)) u_clk_off (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(i_wr_en && (i_addr == `CSC_ADDR_DIV_CLK_OFF)),
        .i_wdata(i_wdata),
        .o_q(q_clk_off)
    );

    // ----------------------------------------
    // Integer mode change tracking
    // ----------------------------------------
    csc_div_t int_mode_flip;

    // Bits that a write flips stay flagged until a soft reset
    assign int_mode_flip = int_mode_we ?
        (i_wdata[`CSC_DIV_HI:0] ^ q_int_mode[`CSC_DIV_HI:0]) : '0;

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    csc_byte_t rd_mux;
    logic rd_hit;
    // Read data is registered in the bank state

    always_comb begin
        rd_mux = `CSC_RST_ZERO;
        rd_hit = 1'b1;
        case (i_addr)
            `CSC_ADDR_RAMP: rd_mux = q_ramp;
            `CSC_ADDR_REF_SRC: rd_mux = q_ref;
            `CSC_ADDR_IO_LEVEL: rd_mux = q_io;
            `CSC_ADDR_IN_BUF: rd_mux = q_in_buf;
            `CSC_ADDR_IN_ROUTE: rd_mux = q_in_route;
            `CSC_ADDR_HYS_LO: rd_mux = q_hys_lo;
            `CSC_ADDR_HYS_HI: rd_mux = q_hys_hi;
            `CSC_ADDR_FB_INT: rd_mux = q_fb_int;
            `CSC_ADDR_HALF_ADD: rd_mux = q_half;
            `CSC_ADDR_DRV_ROUTE: rd_mux = q_drv_route;
            `CSC_ADDR_INT_MODE: rd_mux = q_int_mode;
            `CSC_ADDR_DIV_POWER: rd_mux = q_power;
            `CSC_ADDR_DIV0_FAST: rd_mux = q_fast0;
            `CSC_ADDR_DIV1_FAST: rd_mux = q_fast1;
            `CSC_ADDR_SCRATCH_A: rd_mux = q_scr_a;
            `CSC_ADDR_SCRATCH_B: rd_mux = q_scr_b;
            `CSC_ADDR_FRAC_GATE: rd_mux = q_frac_gate;
            `CSC_ADDR_DIV_CLK_OFF: rd_mux = q_clk_off;
            // Unmapped address reads zero and raises the error pulse
            default: rd_hit = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Bank state
    // ----------------------------------------
    csc_bank_state_t state_reg;
    csc_bank_state_t state_next;

    always_comb begin
        state_next = state_reg;
        // Status pulses stand for one cycle
        state_next.rd_valid = i_rd_en;
        state_next.rd_err = i_rd_en && !rd_hit;
        state_next.wr_ack = i_wr_en;
        if (i_rd_en) begin
            state_next.rdata = rd_mux;
        end
        // New change wins over a soft reset in the same cycle
        if (i_soft_reset) begin
            state_next.int_pending = '0;
        end
        state_next.int_pending = state_next.int_pending | int_mode_flip;
        // Divider runs when powered, routed and its digital clock is not off
        state_next.div_running = q_power[`CSC_DIV_HI:0]
            & q_drv_route[`CSC_DIV_HI:0]
            & ~q_clk_off[`CSC_DIV_HI:0];
        // Inputs run while their buffers are enabled
        state_next.in_running = q_in_buf[`CSC_IN_EN_HI:0];
        state_next.in_frac_running = q_in_buf[`CSC_IN_EN_HI:0]
            & ~q_frac_gate[`CSC_NIB_HI:0];
        // Feedback fractional divider runs unless gated
        state_next.fb_frac_running = ~q_frac_gate[`CSC_FB_GATE_BIT];
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_rdata = state_reg.rdata;
    assign o_rd_valid = state_reg.rd_valid;
    assign o_rd_err = state_reg.rd_err;
    assign o_wr_ack = state_reg.wr_ack;
    assign o_int_mode_pending = state_reg.int_pending;
    assign o_div_running = state_reg.div_running;
    assign o_input_running = state_reg.in_running;
    assign o_input_frac_running = state_reg.in_frac_running;
    assign o_feedback_frac_running = state_reg.fb_frac_running;

    // ----------------------------------------
    // Field outputs
    // ----------------------------------------
    assign o_ramp_switch_en = q_ramp[`CSC_RAMP_EN_BIT];
    assign o_ramp_step_size = q_ramp[`CSC_RAMP_STEP_HI:0];
    assign o_reference_external_source_sel = q_ref[0];
    assign o_io_level_3v3 = q_io[0];
    assign o_input_buffer_en = q_in_buf[`CSC_IN_EN_HI:0];
    assign o_input_pulsed_cmos = q_in_buf[`CSC_IN_PULSED_HI:`CSC_IN_PULSED_LO];
    assign o_input_to_detector_route = q_in_route[`CSC_NIB_HI:0];
    assign o_input_hysteresis_cfg = {q_hys_hi[`CSC_NIB_HI:0], q_hys_lo};
    assign o_feedback_integer_mode = q_fb_int[0];
    assign o_output_div_half_add = q_half[`CSC_DIV_HI:0];
    assign o_synth_to_driver_route = q_drv_route[`CSC_DIV_HI:0];
    assign o_output_div_integer_mode = q_int_mode[`CSC_DIV_HI:0];
    assign o_output_div_power_on = q_power[`CSC_DIV_HI:0];
    assign o_out_div0_fast_range = q_fast0[`CSC_FAST_BIT];
    assign o_out_div1_fast_range = q_fast1[`CSC_FAST_BIT];
    assign o_pll_change_scratch_a = q_scr_a[`CSC_NIB_HI:0];
    assign o_pll_change_scratch_b = q_scr_b[`CSC_NIB_HI:0];
    assign o_input_frac_div_clock_off = q_frac_gate[`CSC_NIB_HI:0];
    assign o_feedback_frac_div_clock_off = q_frac_gate[`CSC_FB_GATE_BIT];
    assign o_output_div_clock_off = q_clk_off[`CSC_DIV_HI:0];
endmodule

// *** csc_defs.svh ***
// Register map constants for the clock synthesizer configuration bank
`ifndef CSC_DEFS_SVH
`define CSC_DEFS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define CSC_ADDR_RAMP 16'h05A6
`define CSC_ADDR_REF_SRC 16'h090E
`define CSC_ADDR_IO_LEVEL 16'h0943
`define CSC_ADDR_IN_BUF 16'h0949
`define CSC_ADDR_IN_ROUTE 16'h094A
`define CSC_ADDR_HYS_LO 16'h094E
`define CSC_ADDR_HYS_HI 16'h094F
`define CSC_ADDR_FB_INT 16'h095E
`define CSC_ADDR_HALF_ADD 16'h0A02
`define CSC_ADDR_DRV_ROUTE 16'h0A03
`define CSC_ADDR_INT_MODE 16'h0A04
`define CSC_ADDR_DIV_POWER 16'h0A05
`define CSC_ADDR_DIV0_FAST 16'h0A14
`define CSC_ADDR_DIV1_FAST 16'h0A1A
`define CSC_ADDR_SCRATCH_A 16'h0B24
`define CSC_ADDR_SCRATCH_B 16'h0B25
`define CSC_ADDR_FRAC_GATE 16'h0B44
`define CSC_ADDR_DIV_CLK_OFF 16'h0B4A

// ----------------------------------------
// Writable bit masks
// ----------------------------------------
`define CSC_MASK_RAMP 8'h0F
`define CSC_MASK_BIT0 8'h01
`define CSC_MASK_BYTE 8'hFF
`define CSC_MASK_NIBBLE 8'h0F
`define CSC_MASK_DIV5 8'h1F
`define CSC_MASK_FAST 8'h08
`define CSC_MASK_FRAC_GATE 8'h2F

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CSC_RST_RAMP 8'h08
`define CSC_RST_ZERO 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CSC_RAMP_STEP_HI 2
`define CSC_RAMP_EN_BIT 3
`define CSC_IN_EN_HI 3
`define CSC_IN_PULSED_LO 4
`define CSC_IN_PULSED_HI 7
`define CSC_FAST_BIT 3
`define CSC_FB_GATE_BIT 5
`define CSC_NIB_HI 3
`define CSC_DIV_HI 4

`endif

// *** csc_pkg.sv ***
// Types shared by the clock synthesizer configuration bank
package csc_pkg;
    typedef logic [15:0] csc_addr_t;
    typedef logic [7:0] csc_byte_t;
    typedef logic [4:0] csc_div_t;
    typedef logic [3:0] csc_in_t;

    typedef struct packed {
        csc_byte_t value;
    } csc_field_state_t;

    typedef struct packed {
        csc_byte_t rdata;
        logic rd_valid;
        logic rd_err;
        logic wr_ack;
        csc_div_t int_pending;
        csc_div_t div_running;
        csc_in_t in_running;
        csc_in_t in_frac_running;
        logic fb_frac_running;
    } csc_bank_state_t;
endpackage

// *** csc_field_reg.sv ***
// One byte-wide configuration register with a writable-bit mask
`timescale 1ns/1ps
module csc_field_reg #(
    parameter logic [7:0] MASK = 8'hFF,
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_we,
    input wire csc_pkg::csc_byte_t i_wdata,
    output csc_pkg::csc_byte_t o_q
);
    import csc_pkg::*;

    csc_field_state_t state_reg;
    csc_field_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (i_we) begin
            state_next.value = i_wdata & MASK;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg.value <= RESET_VAL & MASK;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_q = state_reg.value;
endmodule

// *** csc_regs_monitor.sv ***
// Assertion checker for the configuration register bank
`timescale 1ns/1ps
`include "csc_defs.svh"
module csc_regs_monitor (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wr_en,
    input wire csc_pkg::csc_addr_t i_addr,
    input wire csc_pkg::csc_byte_t i_wdata,
    input wire logic i_soft_reset,
    input wire csc_pkg::csc_byte_t o_rdata,
    input wire logic o_rd_valid,
    input wire logic o_rd_err,
    input wire logic o_wr_ack,
    input wire logic o_ramp_switch_en,
    input wire csc_pkg::csc_in_t o_input_buffer_en,
    input wire csc_pkg::csc_in_t o_input_pulsed_cmos,
    input wire csc_pkg::csc_div_t o_output_div_integer_mode,
    input wire csc_pkg::csc_div_t o_int_mode_pending,
    input wire csc_pkg::csc_div_t o_div_running,
    input wire csc_pkg::csc_div_t o_output_div_power_on,
    input wire csc_pkg::csc_div_t o_synth_to_driver_route,
    input wire csc_pkg::csc_div_t o_output_div_clock_off,
    input wire logic o_feedback_frac_running,
    input wire logic o_feedback_frac_div_clock_off
);
    import csc_pkg::*;
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    csc_div_t run_exp_reg;
    always_ff @(posedge i_clk) begin
        run_exp_reg <= o_output_div_power_on & o_synth_to_driver_route & ~o_output_div_clock_off;
    end
    property p_ramp_rst; $fell(i_rst) |-> o_ramp_switch_en; endproperty
    a_ramp_rst: assert property (p_ramp_rst) else $error("ramp enable not set after reset");
    property p_ramp_wr;
        csc_byte_t d;
        (i_wr_en && i_addr == `CSC_ADDR_RAMP, d = i_wdata) |=> o_ramp_switch_en == d[3];
    endproperty
    a_ramp_wr: assert property (p_ramp_wr) else $error("ramp enable not written");
    property p_in_wr;
        csc_byte_t d;
        (i_wr_en && i_addr == `CSC_ADDR_IN_BUF, d = i_wdata)
            |=> o_input_buffer_en == d[3:0] && o_input_pulsed_cmos == d[7:4];
    endproperty
    a_in_wr: assert property (p_in_wr) else $error("input control mismatch");
    property p_int_wr;
        csc_byte_t d;
        (i_wr_en && i_addr == `CSC_ADDR_INT_MODE, d = i_wdata)
            |=> o_output_div_integer_mode == d[4:0];
    endproperty
    a_int_wr: assert property (p_int_wr) else $error("integer mode mismatch");
    property p_wr_ack; i_wr_en |=> o_wr_ack; endproperty
    a_wr_ack: assert property (p_wr_ack) else $error("write not acknowledged");
    property p_rd_err; o_rd_err |-> o_rd_valid && o_rdata == 8'h00; endproperty
    a_rd_err: assert property (p_rd_err) else $error("unmapped read data not zero");
    property p_soft; i_soft_reset && !i_wr_en |=> o_int_mode_pending == 5'h00; endproperty
    a_soft: assert property (p_soft) else $error("pending not cleared");
    property p_pend_set;
        csc_div_t d;
        (i_wr_en && i_addr == `CSC_ADDR_INT_MODE, d = i_wdata[4:0] ^ o_output_div_integer_mode)
            |=> (o_int_mode_pending & d) == d;
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("pending not set");
    property p_div_run; !$past(i_rst) |-> o_div_running == run_exp_reg; endproperty
    a_div_run: assert property (p_div_run) else $error("divider running wrong");
    property p_fb_run;
        !$past(i_rst) |-> o_feedback_frac_running != $past(o_feedback_frac_div_clock_off);
    endproperty
    a_fb_run: assert property (p_fb_run) else $error("feedback gate wrong");
    c_pend: cover property (o_int_mode_pending != 5'h00);
    c_err: cover property (o_rd_err);
    c_soft: cover property (i_soft_reset ##1 o_int_mode_pending == 5'h00);
endmodule
bind csc_regs csc_regs_monitor i_csc_regs_monitor (.*);

// *** csc_host_model.sv ***
// Behavioural serial host driving the register port
`timescale 1ns/1ps
module csc_host_model #(
    parameter bit HOST_3V3 = 1'b1,
    parameter bit CORE_1V8 = 1'b1
) (
    input wire logic i_clk,
    input wire csc_pkg::csc_byte_t i_rdata,
    input wire logic i_rd_valid,
    input wire logic i_rd_err,
    input wire logic i_wr_ack,
    output logic o_wr_en,
    output logic o_rd_en,
    output csc_pkg::csc_addr_t o_addr,
    output csc_pkg::csc_byte_t o_wdata,
    output logic o_soft_reset
);
    import csc_pkg::*;
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = 16'h0000;
        o_wdata = 8'h00;
        o_soft_reset = 1'b0;
    end
    // ----------------------------------------
    // Accesses, released bus shows inverse
    // ----------------------------------------
    task automatic wr(input csc_addr_t a, input csc_byte_t d, output bit ok);
        @(posedge i_clk);
        #1;
        o_addr = a;
        o_wdata = d;
        o_wr_en = 1'b1;
        @(posedge i_clk);
        #1;
        o_wr_en = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
        ok = (i_wr_ack === 1'b1);
    endtask
    task automatic rd(input csc_addr_t a, output csc_byte_t d, output logic e, output bit ok);
        @(posedge i_clk);
        #1;
        o_addr = a;
        o_rd_en = 1'b1;
        @(posedge i_clk);
        #1;
        o_rd_en = 1'b0;
        o_addr = ~a;
        d = i_rdata;
        e = i_rd_err;
        ok = (i_rd_valid === 1'b1);
    endtask
    task automatic soft_rst;
        @(posedge i_clk);
        #1;
        o_soft_reset = 1'b1;
        @(posedge i_clk);
        #1;
        o_soft_reset = 1'b0;
    endtask
    task automatic bring_up;
        bit k;
        wr(16'h0943, {7'h00, HOST_3V3 & CORE_1V8}, k);
        wr(16'h0A04, 8'h00, k);
        wr(16'h0A05, 8'h1F, k);
        wr(16'h0A03, 8'h1F, k);
        wr(16'h0B4A, 8'h00, k);
    endtask
endmodule

// *** csc_regs_tb_top.sv ***
// Self-checking testbench for the configuration register bank
`timescale 1ns/1ps
module csc_regs_tb_top;
    import csc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr_en, rd_en, soft_rst, rd_valid, rd_err, wr_ack;
    logic ramp_en, ref_sel, io_3v3, fb_run, e;
    csc_addr_t addr;
    csc_byte_t wdata, rdata, d;
    csc_in_t in_en, in_pcmos, in_frac_run;
    csc_div_t pend, div_run;
    wire [63:0] pins;
    bit ok;
    int n_mismatch = 0;
    int total_checks = 0;
    csc_addr_t ra [18] = '{16'h05A6, 16'h090E, 16'h0943, 16'h0949, 16'h094A, 16'h094E,
        16'h094F, 16'h095E, 16'h0A02, 16'h0A03, 16'h0A04, 16'h0A05, 16'h0A14, 16'h0A1A,
        16'h0B24, 16'h0B25, 16'h0B44, 16'h0B4A};
    csc_byte_t rm [18] = '{8'h0F, 8'h01, 8'h01, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'h01,
        8'h1F, 8'h1F, 8'h1F, 8'h1F, 8'h08, 8'h08, 8'h0F, 8'h0F, 8'h2F, 8'h1F};
    csc_addr_t ga [3] = '{16'h0B4A, 16'h0A05, 16'h0A03};
    csc_byte_t gd [3] = '{8'h04, 8'h1E, 8'h0F};
    csc_div_t ge [3] = '{5'h1B, 5'h1A, 5'h0A};
    always #12.5 clk = ~clk;
    csc_host_model i_csc_host_model (.i_clk(clk), .i_rdata(rdata), .i_rd_valid(rd_valid),
        .i_rd_err(rd_err), .i_wr_ack(wr_ack), .o_wr_en(wr_en), .o_rd_en(rd_en),
        .o_addr(addr), .o_wdata(wdata), .o_soft_reset(soft_rst));
    csc_regs i_csc_regs (.i_clk(clk), .i_rst(rst), .i_wr_en(wr_en), .i_rd_en(rd_en),
        .i_addr(addr), .i_wdata(wdata), .i_soft_reset(soft_rst), .o_rdata(rdata),
        .o_rd_valid(rd_valid), .o_rd_err(rd_err), .o_wr_ack(wr_ack),
        .o_ramp_switch_en(ramp_en), .o_ramp_step_size(pins[2:0]),
        .o_reference_external_source_sel(ref_sel), .o_io_level_3v3(io_3v3),
        .o_input_buffer_en(in_en), .o_input_pulsed_cmos(in_pcmos),
        .o_input_to_detector_route(pins[6:3]), .o_input_hysteresis_cfg(pins[18:7]),
        .o_feedback_integer_mode(pins[19]), .o_output_div_half_add(pins[24:20]),
        .o_synth_to_driver_route(pins[29:25]), .o_output_div_integer_mode(pins[34:30]),
        .o_output_div_power_on(pins[39:35]), .o_out_div0_fast_range(pins[40]),
        .o_out_div1_fast_range(pins[41]), .o_pll_change_scratch_a(pins[45:42]),
        .o_pll_change_scratch_b(pins[49:46]), .o_input_frac_div_clock_off(pins[53:50]),
        .o_feedback_frac_div_clock_off(pins[54]), .o_output_div_clock_off(pins[59:55]),
        .o_int_mode_pending(pend), .o_div_running(div_run), .o_input_running(pins[63:60]),
        .o_input_frac_running(in_frac_run), .o_feedback_frac_running(fb_run));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #(5000 * 25);
        n_mismatch++;
        complete_run;
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 18; i++) begin
            i_csc_host_model.rd(ra[i], d, e, ok);
            chk({ok, e, d}, {2'b10, (i == 0) ? 8'h08 : 8'h00});
            i_csc_host_model.wr(ra[i], 8'hFF, ok);
            chk(ok, 1'b1);
            i_csc_host_model.rd(ra[i], d, e, ok);
            chk({e, d}, {1'b0, rm[i]});
        end
        chk(&pins, 1'b1);
        for (int i = 0; i < 18; i++) begin
            i_csc_host_model.wr(ra[i], 8'h00, ok);
        end
        chk(|pins, 1'b0);
        i_csc_host_model.soft_rst;
        chk(pend, 5'h00);
        $display("test map done");
        chk(ramp_en, 1'b0);
        i_csc_host_model.wr(16'h090E, 8'h01, ok);
        chk(ref_sel, 1'b1);
        i_csc_host_model.bring_up;
        chk(io_3v3, 1'b1);
        for (int i = 0; i < 4; i++) begin
            i_csc_host_model.wr(16'h0949, 8'h11 << i, ok);
            chk({in_pcmos, in_en}, 8'h11 << i);
        end
        $display("test fields done");
        i_csc_host_model.wr(16'h0949, 8'h0F, ok);
        i_csc_host_model.wr(16'h0B44, 8'h21, ok);
        @(posedge clk);
        #1;
        chk({fb_run, in_frac_run}, 5'h0E);
        for (int i = 0; i < 3; i++) begin
            i_csc_host_model.wr(ga[i], gd[i], ok);
            @(posedge clk);
            #1;
            chk(div_run, ge[i]);
        end
        $display("test gating done");
        i_csc_host_model.wr(16'h0A04, 8'h05, ok);
        chk(pend, 5'h05);
        i_csc_host_model.soft_rst;
        chk(pend, 5'h00);
        $display("test pending done");
        i_csc_host_model.rd(16'h0A06, d, e, ok);
        chk({e, d}, 9'h100);
        i_csc_host_model.wr(16'h05A5, 8'hFF, ok);
        i_csc_host_model.rd(16'h05A6, d, e, ok);
        chk(d, 8'h00);
        $display("test unmapped done");
        @(posedge clk);
        #1 rst = 1'b1;
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        i_csc_host_model.rd(16'h05A6, d, e, ok);
        chk({d, ramp_en}, 9'h011);
        $display("test reset done");
        complete_run;
    end
endmodule
